/* File: dma_channel_transfer_sequencer.sv */
// single dma channel: register file, read/write sequencer, limit checks
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
// Behaviour
// - all accesses stay in data address space
// - peripheral source, ram destination: read, write
// - ram source, peripheral destination per trigger
// - peripheral to peripheral uses no ram
// - ram to ram starts on any trigger
// - ram accesses confined to limit window
// - above upper limit: high flag, terminate
// - below lower limit: low flag, terminate
// - pending bit 15: load sets, store clears
// - mode field bits 3:2, 00 one-shot
// - trigger or request bit 8 starts load/store
// - update addresses and decrement count together
// - evaluate flags, then wait or continue
// - repeated modes reload at zero count
// - one-shot/continuous clear enable at zero
// - nonzero count: limit crossing disables channel
// - one-shot waits, continuous proceeds immediately
// - one-shot single, continuous multiple per trigger
// - count resets to 0001h
// - reload bit 9 alters modes
// - 01 repeated one-shot, never self-disables
// - 10 continuous, disables at zero
// - 11 repeated continuous, reloads at zero
// - reload bit restores values after completion
module dma_channel_transfer_sequencer
	import dma_seq_pkg::*;
(
	input  wire logic                    i_sys_clk,
	input  wire logic                    i_reset_n,
	// register port
	input  wire logic [REG_ADDR_W-1:0]   i_reg_addr,
	input  wire logic [DATA_W-1:0]       i_reg_wdata,
	input  wire logic                    i_reg_wr,
	input  wire logic                    i_reg_rd,
	output logic [DATA_W-1:0]            o_reg_rdata,
	// hardware trigger from any peripheral, asynchronous
	input  wire logic                    i_hw_trigger,
	// peripheral register bus master
	output logic [ADDR_W-1:0]            o_per_addr,
	output logic [DATA_W-1:0]            o_per_wdata,
	output logic                         o_per_rd,
	output logic                         o_per_wr,
	input  wire logic [DATA_W-1:0]       i_per_rdata,
	// data ram master
	output logic [ADDR_W-1:0]            o_ram_addr,
	output logic [DATA_W-1:0]            o_ram_wdata,
	output logic                         o_ram_rd,
	output logic                         o_ram_wr,
	input  wire logic [DATA_W-1:0]       i_ram_rdata,
	// status levels
	output logic                         o_busy
);
	import dma_seq_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE, ST_READ, ST_LOAD, ST_WRITE, ST_UPDATE
	} seq_state_t;

	seq_state_t       state_reg;         // sequencer state
	logic [15:0]      ctrl_reg;          // channel_control_reg
	logic [15:0]      source_address_reg;
	logic [15:0]      destination_address_reg;
	logic [15:0]      transfer_count_reg;
	logic [15:0]      src_init_reg;      // values restored on reload
	logic [15:0]      dst_init_reg;
	logic [15:0]      cnt_init_reg;
	logic [15:0]      upper_limit_reg;
	logic [15:0]      lower_limit_reg;
	logic [15:0]      transfer_holding_buffer;
	logic             buffer_write_pending;
	logic             high_limit_flag;
	logic             low_limit_flag;
	logic             done_flag;
	logic             src_periph;        // source classified as peripheral
	logic             dst_periph;
	logic [15:0]      cnt_dec;           // count after this transfer
	logic             trig_pulse;        // synchronised hardware trigger
	logic             channel_enable;
	logic             soft_request;
	logic             reload_en;
	xfer_mode_t       transfer_mode_select;
	logic             is_repeated;
	logic             is_continuous;
	logic             wr_ctrl;
	logic             wr_irq;
	region_t          src_region;
	region_t          dst_region;
	logic             src_viol;
	logic             dst_viol;

	assign channel_enable       = ctrl_reg[CTRL_EN_BIT];
	assign soft_request         = ctrl_reg[CTRL_REQ_BIT];
	assign reload_en            = ctrl_reg[CTRL_RELOAD_BIT];
	assign transfer_mode_select = xfer_mode_t'(ctrl_reg[MODE_LO+1:MODE_LO]);
	assign is_repeated   = transfer_mode_select == MODE_REP_ONESHOT
		|| transfer_mode_select == MODE_REP_CONT;
	assign is_continuous = transfer_mode_select == MODE_CONT
		|| transfer_mode_select == MODE_REP_CONT;
	assign wr_ctrl = i_reg_wr && i_reg_addr == OFF_CTRL;
	assign wr_irq  = i_reg_wr && i_reg_addr == OFF_IRQ;
	assign cnt_dec = transfer_count_reg - ONE;
	assign src_periph = src_region == REGION_PERIPH;
	assign dst_periph = dst_region == REGION_PERIPH;
	assign src_viol = src_region == REGION_HIGH || src_region == REGION_LOW;
	assign dst_viol = dst_region == REGION_HIGH || dst_region == REGION_LOW;
	assign o_busy = state_reg != ST_IDLE;

	dma_trig_sync u_trig (
		.i_sys_clk (i_sys_clk),
		.i_reset_n (i_reset_n),
		.i_async   (i_hw_trigger),
		.o_rise    (trig_pulse)
	);

	// limit checking of both pointers
	dma_addr_check u_src_chk (
		.i_addr   (source_address_reg),
		.i_upper  (upper_limit_reg),
		.i_lower  (lower_limit_reg),
		.o_region (src_region)
	);
	dma_addr_check u_dst_chk (
		.i_addr   (destination_address_reg),
		.i_upper  (upper_limit_reg),
		.i_lower  (lower_limit_reg),
		.o_region (dst_region)
	);

	// sequencer: idle -> read -> load -> write -> update
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					// any trigger starts even a ram-to-ram move
					if (channel_enable && (soft_request || trig_pulse)) begin
						state_reg <= ST_READ;
					end
				end
				ST_READ: begin
					// out-of-window source terminates before the read
					state_reg <= src_viol ? ST_UPDATE : ST_LOAD;
				end
				ST_LOAD: begin
					state_reg <= ST_WRITE;
				end
				ST_WRITE: begin
					state_reg <= ST_UPDATE;
				end
				ST_UPDATE: begin
					// continuous modes go straight on, one-shot waits
					if (ctrl_reg[CTRL_EN_BIT] && is_continuous && !high_limit_flag
						&& !low_limit_flag && !src_viol && !dst_viol
						&& (transfer_count_reg != ONE || is_repeated)) begin
						state_reg <= ST_READ;
					end else begin
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// bus strobes: peripheral addresses go to the peripheral bus, in-window addresses to ram
	always_comb begin
		o_per_rd   = state_reg == ST_READ && !src_viol && src_periph;
		o_ram_rd   = state_reg == ST_READ && !src_viol && !src_periph;
		o_per_wr   = state_reg == ST_WRITE && !dst_viol && dst_periph;
		o_ram_wr   = state_reg == ST_WRITE && !dst_viol && !dst_periph;
		o_per_addr = state_reg == ST_WRITE ? destination_address_reg : source_address_reg;
		o_ram_addr = state_reg == ST_WRITE ? destination_address_reg : source_address_reg;
	end
	assign o_per_wdata = transfer_holding_buffer;
	assign o_ram_wdata = transfer_holding_buffer;

	// holding buffer captures the read data the cycle after the read strobe
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			transfer_holding_buffer <= ZERO;
		end else if (state_reg == ST_LOAD) begin
			transfer_holding_buffer <= src_periph ? i_per_rdata : i_ram_rdata;
		end
	end

	// control register: software writes, hardware clears enable and request
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			ctrl_reg <= ZERO;
		end else begin
			if (wr_ctrl) begin
				ctrl_reg <= i_reg_wdata;
			end
			if (trig_pulse && channel_enable && state_reg == ST_IDLE) begin
				ctrl_reg[CTRL_REQ_BIT] <= 1'b1; // hardware trigger shows as request
			end
			if (state_reg == ST_UPDATE) begin
				// request drops once the started transfer has finished
				if (!is_continuous || transfer_count_reg == ONE || src_viol || dst_viol) begin
					ctrl_reg[CTRL_REQ_BIT] <= 1'b0;
				end
				if (src_viol || dst_viol) begin
					ctrl_reg[CTRL_EN_BIT] <= 1'b0; // limit crossing stops channel
				end else if (transfer_count_reg == ONE && !is_repeated) begin
					ctrl_reg[CTRL_EN_BIT] <= 1'b0; // self-disable at zero
				end
			end
		end
	end

	// pointers and count; software writes also set the reload image
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			source_address_reg      <= ZERO;
			destination_address_reg <= ZERO;
			transfer_count_reg      <= CNT_RESET;
			src_init_reg            <= ZERO;
			dst_init_reg            <= ZERO;
			cnt_init_reg            <= CNT_RESET;
		end else if (state_reg == ST_UPDATE && !src_viol && !dst_viol) begin
			if (transfer_count_reg == ONE) begin
				// count always reloads; pointers reload in repeated modes or with reload
				transfer_count_reg <= cnt_init_reg;
				if (is_repeated || reload_en) begin
					source_address_reg      <= src_init_reg;
					destination_address_reg <= dst_init_reg;
				end else begin
					source_address_reg      <= ctrl_reg[CTRL_SINC_BIT]
						? source_address_reg + ADDR_STEP : source_address_reg;
					destination_address_reg <= ctrl_reg[CTRL_DINC_BIT]
						? destination_address_reg + ADDR_STEP : destination_address_reg;
				end
			end else begin
				// step pointers and count in the same cycle
				transfer_count_reg      <= cnt_dec;
				source_address_reg      <= ctrl_reg[CTRL_SINC_BIT]
					? source_address_reg + ADDR_STEP : source_address_reg;
				destination_address_reg <= ctrl_reg[CTRL_DINC_BIT]
					? destination_address_reg + ADDR_STEP : destination_address_reg;
			end
		end else if (i_reg_wr) begin
			case (i_reg_addr)
				OFF_SRC: begin
					source_address_reg <= i_reg_wdata;
					src_init_reg       <= i_reg_wdata;
				end
				OFF_DST: begin
					destination_address_reg <= i_reg_wdata;
					dst_init_reg            <= i_reg_wdata;
				end
				OFF_CNT: begin
					transfer_count_reg <= i_reg_wdata;
					cnt_init_reg       <= i_reg_wdata;
				end
				default: begin
				end
			endcase
		end
	end

	// global limits
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			upper_limit_reg <= UPPER_RESET;
			lower_limit_reg <= LOWER_RESET;
		end else if (i_reg_wr && i_reg_addr == OFF_UPPER) begin
			upper_limit_reg <= i_reg_wdata;
		end else if (i_reg_wr && i_reg_addr == OFF_LOWER) begin
			lower_limit_reg <= i_reg_wdata;
		end
	end

	// flags: hardware set wins over software write of zero
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			buffer_write_pending <= 1'b0;
			high_limit_flag      <= 1'b0;
			low_limit_flag       <= 1'b0;
			done_flag            <= 1'b0;
		end else begin
			if (wr_irq) begin
				buffer_write_pending <= i_reg_wdata[IRQ_PEND_BIT];
				high_limit_flag      <= i_reg_wdata[IRQ_HIGH_BIT];
				low_limit_flag       <= i_reg_wdata[IRQ_LOW_BIT];
				done_flag            <= i_reg_wdata[IRQ_DONE_BIT];
			end
			if (state_reg == ST_LOAD) begin
				buffer_write_pending <= 1'b1;
			end else if (state_reg == ST_WRITE && !dst_viol) begin
				buffer_write_pending <= 1'b0;
			end
			if (state_reg == ST_UPDATE) begin
				// flags evaluated after each transaction
				if (src_region == REGION_HIGH || dst_region == REGION_HIGH) begin
					high_limit_flag <= 1'b1;
				end
				if (src_region == REGION_LOW || dst_region == REGION_LOW) begin
					low_limit_flag <= 1'b1;
				end
				if (transfer_count_reg == ONE && !src_viol && !dst_viol) begin
					done_flag <= 1'b1;
				end
			end
		end
	end

	// read data one cycle after the read strobe; unmapped reads return zero
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			o_reg_rdata <= ZERO;
		end else if (i_reg_rd) begin
			case (i_reg_addr)
				OFF_CTRL:  o_reg_rdata <= ctrl_reg;
				OFF_IRQ: begin
					o_reg_rdata <= ZERO;
					o_reg_rdata[IRQ_PEND_BIT] <= buffer_write_pending;
					o_reg_rdata[IRQ_HIGH_BIT] <= high_limit_flag;
					o_reg_rdata[IRQ_LOW_BIT]  <= low_limit_flag;
					o_reg_rdata[IRQ_DONE_BIT] <= done_flag;
				end
				OFF_SRC:   o_reg_rdata <= source_address_reg;
				OFF_DST:   o_reg_rdata <= destination_address_reg;
				OFF_CNT:   o_reg_rdata <= transfer_count_reg;
				OFF_UPPER: o_reg_rdata <= upper_limit_reg;
				OFF_LOWER: o_reg_rdata <= lower_limit_reg;
				OFF_BUF:   o_reg_rdata <= transfer_holding_buffer;
				default:   o_reg_rdata <= ZERO;
			endcase
		end else begin
			o_reg_rdata <= ZERO;
		end
	end
endmodule

/* File: dma_seq_pkg.sv */
// shared constants for the channel transfer sequencer
package dma_seq_pkg;
	localparam int ADDR_W = 16;                     // address width
	localparam int DATA_W = 16;                     // data width
	localparam int REG_ADDR_W = 4;                  // register port address width
	// register offsets
	localparam logic [3:0] OFF_CTRL  = 4'h0;        // channel_control_reg
	localparam logic [3:0] OFF_IRQ   = 4'h1;        // channel_irq_reg
	localparam logic [3:0] OFF_SRC   = 4'h2;        // source_address_reg
	localparam logic [3:0] OFF_DST   = 4'h3;        // destination_address_reg
	localparam logic [3:0] OFF_CNT   = 4'h4;        // transfer_count_reg
	localparam logic [3:0] OFF_UPPER = 4'h5;        // upper_limit_reg
	localparam logic [3:0] OFF_LOWER = 4'h6;        // lower_limit_reg
	localparam logic [3:0] OFF_BUF   = 4'h7;        // transfer_holding_buffer (read only)
	// control fields
	localparam int CTRL_EN_BIT = 0;                 // channel_enable
	localparam int CTRL_SINC_BIT = 6;               // source increments when set
	localparam int CTRL_DINC_BIT = 4;               // destination increments when set
	localparam int CTRL_REQ_BIT = 8;                // soft_request
	localparam int CTRL_RELOAD_BIT = 9;             // reload control
	localparam int MODE_LO = 2;                     // transfer_mode_select low bit
	// irq fields
	localparam int IRQ_LOW_BIT = 1;                 // low_limit_flag
	localparam int IRQ_HIGH_BIT = 2;                // high_limit_flag
	localparam int IRQ_DONE_BIT = 4;                // count reached zero
	localparam int IRQ_PEND_BIT = 15;               // buffer_write_pending
	// reset values and region
	localparam logic [15:0] CNT_RESET   = 16'h0001; // count after reset
	localparam logic [15:0] PERIPH_END  = 16'h0800; // first address above peripheral region
	localparam logic [15:0] UPPER_RESET = 16'hffff; // limits open after reset
	localparam logic [15:0] LOWER_RESET = 16'h0800;
	localparam logic [15:0] ADDR_STEP   = 16'h0002; // word step
	localparam logic [15:0] ONE         = 16'h0001;
	localparam logic [15:0] ZERO        = 16'h0000;
	typedef enum logic [1:0] {
		MODE_ONESHOT, MODE_REP_ONESHOT, MODE_CONT, MODE_REP_CONT
	} xfer_mode_t;
	typedef enum logic [1:0] {
		REGION_PERIPH, REGION_OK, REGION_LOW, REGION_HIGH
	} region_t;
endpackage

/* File: dma_addr_check.sv */
// classifies one address against the peripheral region and the limits
`timescale 1ns/1ps
module dma_addr_check
	import dma_seq_pkg::*;
(
	input  wire logic [15:0]             i_addr,
	input  wire logic [15:0]             i_upper,
	input  wire logic [15:0]             i_lower,
	output dma_seq_pkg::region_t         o_region
);
	// peripheral region is never limit checked; above it the window applies
	always_comb begin
		if (i_addr < PERIPH_END) begin
			o_region = REGION_PERIPH;
		end else if (i_addr > i_upper) begin
			o_region = REGION_HIGH;
		end else if (i_addr < i_lower) begin
			o_region = REGION_LOW;
		end else begin
			o_region = REGION_OK;
		end
	end
endmodule

/* File: dma_trig_sync.sv */
// three-stage synchroniser with rising-edge pulse for the hardware trigger
`timescale 1ns/1ps
module dma_trig_sync (
	input  wire logic i_sys_clk,
	input  wire logic i_reset_n,
	input  wire logic i_async,
	output logic      o_rise
);
	logic s1_reg; // metastability stage, read only by s2
	logic s2_reg;
	logic s3_reg;
	logic lvl_reg; // accepted level, changes once s2 and s3 agree
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			s1_reg  <= 1'b0;
			s2_reg  <= 1'b0;
			s3_reg  <= 1'b0;
			lvl_reg <= 1'b0;
		end else begin
			s1_reg <= i_async;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				lvl_reg <= s3_reg;
			end
		end
	end
	// one-cycle pulse when the accepted level rises
	assign o_rise = (s2_reg == s3_reg) && s3_reg && !lvl_reg;
endmodule

/* File: dma_seq_asserts.sv */
// port-level assertions for the channel transfer sequencer
`timescale 1ns/1ps
module dma_seq_asserts
	import dma_seq_pkg::*;
(
	input  wire logic              i_sys_clk,
	input  wire logic              i_reset_n,
	input  wire logic [3:0]        i_reg_addr,
	input  wire logic [15:0]       i_reg_wdata,
	input  wire logic              i_reg_wr,
	input  wire logic [15:0]       o_per_addr,
	input  wire logic [15:0]       o_per_wdata,
	input  wire logic              o_per_rd,
	input  wire logic              o_per_wr,
	input  wire logic [15:0]       i_per_rdata,
	input  wire logic [15:0]       o_ram_addr,
	input  wire logic [15:0]       o_ram_wdata,
	input  wire logic              o_ram_rd,
	input  wire logic              o_ram_wr,
	input  wire logic [15:0]       i_ram_rdata,
	input  wire logic              o_busy
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);
	wire logic any_rd = o_per_rd | o_ram_rd;          // a source access this cycle
	wire logic any_wr = o_per_wr | o_ram_wr;          // a destination access this cycle
	wire logic ctrl_wr = i_reg_wr && (i_reg_addr == OFF_CTRL);
	// a start only counts when the channel is idle, busy triggers are dropped
	wire logic start_req = ctrl_wr && i_reg_wdata[CTRL_EN_BIT]
		&& i_reg_wdata[CTRL_REQ_BIT] && !o_busy;
	logic [1:0] mode_reg;                             // last mode written by software
	// mirror of the mode field, needed to tell one-shot from continuous
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			mode_reg <= 2'b00;
		end else if (ctrl_wr) begin
			mode_reg <= i_reg_wdata[3:2];
		end
	end
	a_per_read_route: assert property (o_per_rd |-> o_per_addr < PERIPH_END)
		else $error("peripheral read above region");
	a_ram_read_route: assert property (o_ram_rd |-> o_ram_addr >= PERIPH_END)
		else $error("ram read inside peripheral region");
	a_per_write_route: assert property (o_per_wr |-> o_per_addr < PERIPH_END)
		else $error("peripheral write above region");
	a_ram_write_route: assert property (o_ram_wr |-> o_ram_addr >= PERIPH_END)
		else $error("ram write inside peripheral region");
	a_load_before_store: assert property (any_wr |-> $past(any_rd, 2))
		else $error("store without a load two cycles before");
	a_ram_store_data: assert property (o_ram_wr |->
		o_ram_wdata == ($past(o_per_rd, 2) ? $past(i_per_rdata) : $past(i_ram_rdata)))
		else $error("ram store data differs from loaded item");
	a_per_store_data: assert property (o_per_wr |->
		o_per_wdata == ($past(o_per_rd, 2) ? $past(i_per_rdata) : $past(i_ram_rdata)))
		else $error("peripheral store data differs from loaded item");
	a_request_starts: assert property (start_req |-> ##[1:3] any_rd)
		else $error("software request did not start a load");
	a_idle_quiet: assert property (!o_busy |-> !(any_rd || any_wr))
		else $error("bus access while idle");
	a_oneshot_stops: assert property (any_wr && !mode_reg[1] |-> ##[1:3] !o_busy)
		else $error("one-shot mode kept transferring");
	c_per_to_ram: cover property (o_per_rd ##2 o_ram_wr);
	c_ram_to_per: cover property (o_ram_rd ##2 o_per_wr);
	c_per_to_per: cover property (o_per_rd ##2 o_per_wr);
endmodule
bind dma_channel_transfer_sequencer dma_seq_asserts dma_seq_asserts_inst (.i_sys_clk, .i_reset_n,
	.i_reg_addr, .i_reg_wdata, .i_reg_wr, .o_per_addr, .o_per_wdata, .o_per_rd, .o_per_wr,
	.i_per_rdata, .o_ram_addr, .o_ram_wdata, .o_ram_rd, .o_ram_wr, .i_ram_rdata, .o_busy);

/* File: dma_far_model.sv */
// peripheral register and data ram models on the far side of the channel
`timescale 1ns/1ps
module dma_far_model (
	input  wire logic        i_sys_clk,
	input  wire logic [15:0] i_per_addr,
	input  wire logic [15:0] i_per_wdata,
	input  wire logic        i_per_rd,
	input  wire logic        i_per_wr,
	output logic [15:0]      o_per_rdata,
	input  wire logic [15:0] i_ram_addr,
	input  wire logic [15:0] i_ram_wdata,
	input  wire logic        i_ram_rd,
	input  wire logic        i_ram_wr,
	output logic [15:0]      o_ram_rdata
);
	logic [15:0] per_mem [256]; // word-indexed, address bits 8:1 only
	logic [15:0] ram_mem [256]; // small window aliases, tests keep indices apart
	initial o_per_rdata = 16'h0000;
	initial o_ram_rdata = 16'h0000;
	// answers one cycle after a read; otherwise toggles so stale data never looks valid
	always @(posedge i_sys_clk) begin
		if (i_per_wr) begin
			per_mem[i_per_addr[8:1]] <= i_per_wdata;
		end
		if (i_ram_wr) begin
			ram_mem[i_ram_addr[8:1]] <= i_ram_wdata;
		end
		o_per_rdata <= i_per_rd ? per_mem[i_per_addr[8:1]] : ~o_per_rdata;
		o_ram_rdata <= i_ram_rd ? ram_mem[i_ram_addr[8:1]] : ~o_ram_rdata;
	end
endmodule

/* File: tb_top.sv */
// self-checking bench for the channel transfer sequencer
`timescale 1ns/1ps
module tb_top;
	import dma_seq_pkg::*;
	logic        i_sys_clk = 1'b0;   // 200 mhz
	logic        i_reset_n = 1'b0;
	logic [3:0]  i_reg_addr = 4'h0;
	logic [15:0] i_reg_wdata = 16'h0000;
	logic        i_reg_wr = 1'b0;
	logic        i_reg_rd = 1'b0;
	logic        i_hw_trigger = 1'b0;
	logic [15:0] o_reg_rdata, o_per_addr, o_per_wdata, i_per_rdata;
	logic [15:0] o_ram_addr, o_ram_wdata, i_ram_rdata;
	logic        o_per_rd, o_per_wr, o_ram_rd, o_ram_wr, o_busy;
	int          failures = 0;
	int          total_checks = 0;
	int          ram_hits = 0;       // ram strobes seen
	int          wr_hits = 0;        // store strobes seen
	always #2.5 i_sys_clk = ~i_sys_clk;
	// strobe tallies, sampled before this edge's updates land
	always @(posedge i_sys_clk) begin
		ram_hits += o_ram_rd + o_ram_wr;
		wr_hits += o_ram_wr + o_per_wr;
	end
	dma_channel_transfer_sequencer dma_channel_transfer_sequencer_inst (.i_sys_clk, .i_reset_n,
		.i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_hw_trigger,
		.o_per_addr, .o_per_wdata, .o_per_rd, .o_per_wr, .i_per_rdata,
		.o_ram_addr, .o_ram_wdata, .o_ram_rd, .o_ram_wr, .i_ram_rdata, .o_busy);
	dma_far_model dma_far_model_inst (.i_sys_clk, .i_per_addr(o_per_addr),
		.i_per_wdata(o_per_wdata), .i_per_rd(o_per_rd), .i_per_wr(o_per_wr),
		.o_per_rdata(i_per_rdata), .i_ram_addr(o_ram_addr), .i_ram_wdata(o_ram_wdata),
		.i_ram_rd(o_ram_rd), .i_ram_wr(o_ram_wr), .o_ram_rdata(i_ram_rdata));
	task automatic end_sim;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one-cycle write strobe
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge i_sys_clk);
		i_reg_addr <= a;
		i_reg_wdata <= d;
		i_reg_wr <= 1'b1;
		@(posedge i_sys_clk);
		i_reg_wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rdchk(input logic [3:0] a, input logic [15:0] e);
		@(posedge i_sys_clk);
		i_reg_addr <= a;
		i_reg_rd <= 1'b1;
		@(posedge i_sys_clk);
		i_reg_rd <= 1'b0;
		#1 chk(o_reg_rdata, e);
	endtask
	// the trigger passes a synchroniser, so the first poll comes late
	task automatic wait_idle;
		int n;
		repeat (8) @(posedge i_sys_clk);
		#1;
		for (n = 0; n < 300 && o_busy !== 1'b0; n++) begin
			@(posedge i_sys_clk);
			#1;
		end
		if (n == 300) begin
			failures++;
			$display("Error %0t: channel stuck busy", $time);
			end_sim();
		end
	endtask
	task automatic cfg(input logic [15:0] s, d, c, ctl);
		wr(OFF_SRC, s);
		wr(OFF_DST, d);
		wr(OFF_CNT, c);
		wr(OFF_IRQ, ZERO);
		wr(OFF_CTRL, ctl);
	endtask
	// level held long enough for the synchroniser to see a rising edge
	task automatic trig;
		@(posedge i_sys_clk);
		i_hw_trigger <= 1'b1;
		repeat (4) @(posedge i_sys_clk);
		i_hw_trigger <= 1'b0;
	endtask
	task automatic t_reset;
		rdchk(OFF_CNT, 16'h0001);
		rdchk(OFF_UPPER, 16'hffff);
		rdchk(OFF_LOWER, 16'h0800);
		rdchk(4'h8, ZERO);
	endtask
	task automatic t_oneshot;
		dma_far_model_inst.ram_mem[0] = 16'ha5a1;
		dma_far_model_inst.ram_mem[1] = 16'ha5a2;
		cfg(16'h1000, 16'h1100, 16'h0002, 16'h0151);
		wait_idle();
		chk(dma_far_model_inst.ram_mem[8'h80], 16'ha5a1);
		rdchk(OFF_CTRL, 16'h0051);
		rdchk(OFF_SRC, 16'h1002);
		rdchk(OFF_CNT, 16'h0001);
		rdchk(OFF_IRQ, ZERO);
		wr(OFF_CTRL, 16'h0151);
		wait_idle();
		chk(dma_far_model_inst.ram_mem[8'h81], 16'ha5a2);
		rdchk(OFF_CTRL, 16'h0050);
		rdchk(OFF_CNT, 16'h0002);
		rdchk(OFF_IRQ, 16'h0010);
		// one-shot with reload set: pointers come back to their start values
		cfg(16'h1000, 16'h1100, 16'h0001, 16'h0351);
		wait_idle();
		rdchk(OFF_SRC, 16'h1000);
		rdchk(OFF_DST, 16'h1100);
		rdchk(OFF_CTRL, 16'h0250);
	endtask
	// peripheral pairs with a hardware trigger, ram to peripheral by request
	task automatic t_routes;
		int h;
		dma_far_model_inst.per_mem[8'h80] = 16'h1234;
		dma_far_model_inst.ram_mem[2] = 16'hbeef;
		cfg(16'h0100, 16'h1000, 16'h0001, 16'h0001);
		trig();
		wait_idle();
		chk(dma_far_model_inst.ram_mem[0], 16'h1234);
		rdchk(OFF_CTRL, ZERO);
		cfg(16'h1004, 16'h0200, 16'h0001, 16'h0101);
		wait_idle();
		chk(dma_far_model_inst.per_mem[0], 16'hbeef);
		h = ram_hits;
		cfg(16'h0100, 16'h0302, 16'h0001, 16'h0001);
		trig();
		wait_idle();
		chk(dma_far_model_inst.per_mem[8'h81], 16'h1234);
		chk(16'(ram_hits - h), ZERO);
	endtask
	task automatic t_cont;
		for (int i = 0; i < 3; i++) dma_far_model_inst.ram_mem[8'h10 + i] = 16'h7000 + 16'(i);
		cfg(16'h1020, 16'h1120, 16'h0003, 16'h0059);
		trig();
		wait_idle();
		for (int i = 0; i < 3; i++) begin
			chk(dma_far_model_inst.ram_mem[8'h90 + i], 16'h7000 + 16'(i));
		end
		rdchk(OFF_CTRL, 16'h0058);
		rdchk(OFF_CNT, 16'h0003);
	endtask
	task automatic t_repeat;
		dma_far_model_inst.ram_mem[8'h20] = 16'h4242;
		dma_far_model_inst.ram_mem[8'h30] = 16'h6161;
		// second source word of the looping run, so no unknown item is moved
		dma_far_model_inst.ram_mem[8'h31] = 16'h6162;
		cfg(16'h1040, 16'h1140, 16'h0001, 16'h0355);
		wait_idle();
		chk(dma_far_model_inst.ram_mem[8'ha0], 16'h4242);
		rdchk(OFF_CTRL, 16'h0255);
		rdchk(OFF_SRC, 16'h1040);
		rdchk(OFF_CNT, 16'h0001);
		cfg(16'h1060, 16'h1160, 16'h0002, 16'h035d);
		repeat (40) @(posedge i_sys_clk);
		chk(dma_far_model_inst.ram_mem[8'hb0], 16'h6161);
		rdchk(OFF_CTRL, 16'h025d);
		wr(OFF_CTRL, ZERO);
		wait_idle();
	endtask
	// destination outside the window: item stays buffered, software reads it back
	task automatic t_limits;
		int h;
		dma_far_model_inst.ram_mem[0] = 16'h5a5a;
		wr(OFF_UPPER, 16'h2000);
		h = wr_hits;
		cfg(16'h1000, 16'h3000, 16'h0002, 16'h0101);
		wait_idle();
		chk(16'(wr_hits - h), ZERO);
		rdchk(OFF_IRQ, 16'h8004);
		rdchk(OFF_BUF, 16'h5a5a);
		rdchk(OFF_CNT, 16'h0002);
		wr(OFF_UPPER, 16'hffff);
		wr(OFF_LOWER, 16'h1000);
		cfg(16'h1000, 16'h0900, 16'h0002, 16'h0101);
		wait_idle();
		chk(16'(wr_hits - h), ZERO);
		rdchk(OFF_IRQ, 16'h8002);
		wr(OFF_LOWER, 16'h0800);
	endtask
	initial begin
		repeat (2) @(posedge i_sys_clk);
		i_reset_n <= 1'b1;
		t_reset();
		t_oneshot();
		t_routes();
		t_cont();
		t_repeat();
		t_limits();
		end_sim();
	end
endmodule
